// >>> design/wst_pkg.sv
package wst_pkg;

    // register bus geometry
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;

    // register byte offsets
    localparam logic [7:0]  CTRL_OFF       = 8'h00;
    localparam logic [7:0]  RELOAD_OFF     = 8'h04;
    localparam logic [7:0]  WINB_OFF       = 8'h08;
    localparam logic [7:0]  STATUS_OFF     = 8'h0C;
    localparam logic [7:0]  MASK_OFF       = 8'h10;
    localparam logic [7:0]  COUNT_OFF      = 8'h14;

    // control register fields
    localparam int          CTRL_SEL_BIT   = 0;
    localparam int          CTRL_WIN_BIT   = 1;

    // status and mask fields
    localparam int          EV_W           = 3;
    localparam int          EV_OVF_BIT     = 0;
    localparam int          EV_INV_BIT     = 1;
    localparam int          EV_RST_BIT     = 2;

    // reset values
    localparam logic [7:0]  RELOAD_RST     = 8'h00;
    localparam logic [7:0]  WINB_RST       = 8'h00;
    localparam logic [2:0]  MASK_RST       = 3'h0;
    localparam logic [15:0] COUNT_RST      = 16'h0000;

    // count clock dividers and prewarning length in count ticks
    localparam logic [7:0]  FAST_DIV       = 8'h02;
    localparam logic [7:0]  SLOW_DIV       = 8'h80;
    localparam logic [7:0]  PREWARN_COUNTS = 8'h30;
    localparam logic [7:0]  BYTE_MAX       = 8'hFF;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;

    typedef enum logic [2:0] {
        ST_COUNT   = 3'b001,
        ST_PREWARN = 3'b010,
        ST_RESET   = 3'b100
    } wdt_state_type;

    // divide ratio for a prescale select value
    function automatic logic [7:0] div_of(input logic sel);
        return sel ? SLOW_DIV : FAST_DIV;
    endfunction

endpackage

// >>> design/prescale_tick.sv
module prescale_tick #(
    parameter logic [7:0] FAST = 8'h02,
    parameter logic [7:0] SLOW = 8'h80
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    input  wire logic run,
    input  wire logic restart,
    input  wire logic sel,
    // one-cycle count enable
    output wire logic tick
);
    import wst_pkg::*;

    // dividers below two cannot produce a tick gap
    if (FAST < 8'h02 || SLOW < FAST) begin : g_bad_div
        $error("prescale_tick: divider values unusable");
    end

    logic [7:0] div_cnt_ff;
    logic [7:0] nxt_div_cnt;
    wire  [7:0] div_last = (sel ? SLOW : FAST) - 8'h01;

    // tick on the last phase of the divider, only while running
    assign tick        = run && !restart && (div_cnt_ff == div_last);
    assign nxt_div_cnt = (restart || tick) ? BYTE_ZERO :
                         run ? div_cnt_ff + 8'h01 : div_cnt_ff;

    // restart realigns the phase so a service period is exact
    always_ff @(posedge clk) begin
        if (rst)
            div_cnt_ff <= BYTE_ZERO;
        else
            div_cnt_ff <= nxt_div_cnt;
    end

endmodule // prescale_tick

// >>> design/service_timer.sv
// Notes on behaviour
// - sixteen-bit up-counter made of two eight-bit stages, low carries into high
// - count rate is clock over 2 with select 0, over 128 with select 1
// - each accepted service loads reload byte high and clears the low byte
// - after service counting resumes upward from reload byte times 256
// - overflow without service raises timeout interrupt and enters prewarning
// - prewarning lasts 30 hex count ticks, then system reset is requested
// - refresh inside active window is invalid: prewarning without timeout interrupt, then reset
// - forbidden window spans 0000 up to window bound byte followed by 00
// - counting is frozen while the processor is in debug mode
// - service to overflow takes 2^(1+6*sel) times (65536-256*reload) clocks
module service_timer
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // register port
    input  wire logic [wst_pkg::ADDR_W-1:0] addr,
    input  wire logic [wst_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output wire logic [wst_pkg::DATA_W-1:0] rdata,
    // software service strobe, same clock
    input  wire logic                       service_strobe,
    // processor debug state, asynchronous pin
    input  wire logic                       debug_mode,
    // outputs to the system
    output wire logic                       timeout_nmi,
    output wire logic                       system_reset_request,
    output wire logic                       irq
);
    import wst_pkg::*;

    // debug pin synchroniser
    logic              dbg_meta_ff;
    logic              dbg_sync_ff;

    // software visible state
    logic              sel_ff;
    logic              win_en_ff;
    logic [7:0]        reload_ff;
    logic [7:0]        winb_ff;
    logic [EV_W-1:0]   mask_ff;
    logic [EV_W-1:0]   status_ff;
    logic [DATA_W-1:0] rdata_ff;

    // timer core
    logic [7:0]        lo_ff;
    logic [7:0]        hi_ff;
    logic [7:0]        pw_cnt_ff;
    logic              nmi_ff;
    logic              rst_req_ff;
    wdt_state_type     state_ff;
    wdt_state_type     nxt_state;

    logic [7:0]        nxt_lo;
    logic [7:0]        nxt_hi;
    logic [7:0]        nxt_pw_cnt;
    logic [EV_W-1:0]   nxt_status;
    logic [DATA_W-1:0] nxt_rdata;

    // register decode
    wire wr_ctrl   = wr_en && (addr == CTRL_OFF);
    wire wr_reload = wr_en && (addr == RELOAD_OFF);
    wire wr_winb   = wr_en && (addr == WINB_OFF);
    wire wr_mask   = wr_en && (addr == MASK_OFF);
    wire rd_status = rd_en && (addr == STATUS_OFF);

    wire [15:0] count_val = {hi_ff, lo_ff};
    wire        counting  = (state_ff == ST_COUNT);

    // window bound
    // upper end is inclusive: a refresh becomes legal once the count passes it
    wire [15:0] win_top   = {winb_ff, BYTE_ZERO};
    wire        in_window = win_en_ff && (count_val <= win_top);

    wire svc_accept  = service_strobe && counting && !in_window;
    wire svc_invalid = service_strobe && counting && in_window;

    // debug freeze
    // the reset state needs no ticks, so the divider rests there too
    wire run      = !dbg_sync_ff && (state_ff != ST_RESET);
    wire restart  = svc_accept || svc_invalid || wr_ctrl;
    wire cnt_tick;

    prescale_tick #(
        .FAST    (FAST_DIV),
        .SLOW    (SLOW_DIV)
    ) u_prescale (
        .clk     (clk),
        .rst     (rst),
        .run     (run),
        .restart (restart),
        .sel     (sel_ff),
        .tick    (cnt_tick)
    );

    wire lo_carry = (lo_ff == BYTE_MAX);

    // overflow point
    // a strobe in the overflow cycle counts as service, never as overflow
    wire overflow = counting && cnt_tick && lo_carry && (hi_ff == BYTE_MAX)
                    && !service_strobe;

    wire pw_done  = (state_ff == ST_PREWARN) && cnt_tick
                    && (pw_cnt_ff == PREWARN_COUNTS - 8'h01);

    // events feeding the status register
    wire [EV_W-1:0] events = {pw_done, svc_invalid, overflow};

    always_comb begin
        nxt_lo = lo_ff;
        nxt_hi = hi_ff;
        if (svc_accept) begin
            nxt_lo = BYTE_ZERO;
            nxt_hi = reload_ff;
        end else if (counting && cnt_tick) begin
            nxt_lo = lo_ff + 8'h01;
            nxt_hi = hi_ff + {7'h00, lo_carry};
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_COUNT: begin
                if (overflow || svc_invalid)
                    nxt_state = ST_PREWARN;
            end
            ST_PREWARN: begin
                if (pw_done)
                    nxt_state = ST_RESET;
            end
            ST_RESET: begin
                nxt_state = ST_RESET;
            end
            default: begin
                nxt_state = ST_COUNT;
            end
        endcase
    end

    assign nxt_pw_cnt = (state_ff != ST_PREWARN) ? BYTE_ZERO :
                        cnt_tick ? pw_cnt_ff + 8'h01 : pw_cnt_ff;

    // sticky status: a read clears, a same-cycle event still sets
    assign nxt_status = (rd_status ? {EV_W{1'b0}} : status_ff) | events;

    // read data mux, unmapped offsets read zero
    assign nxt_rdata =
        !rd_en                 ? {DATA_W{1'b0}} :
        (addr == CTRL_OFF)     ? {{(DATA_W-2){1'b0}}, win_en_ff, sel_ff} :
        (addr == RELOAD_OFF)   ? {{(DATA_W-8){1'b0}}, reload_ff} :
        (addr == WINB_OFF)     ? {{(DATA_W-8){1'b0}}, winb_ff} :
        (addr == STATUS_OFF)   ? {{(DATA_W-EV_W){1'b0}}, status_ff} :
        (addr == MASK_OFF)     ? {{(DATA_W-EV_W){1'b0}}, mask_ff} :
        (addr == COUNT_OFF)    ? {{(DATA_W-16){1'b0}}, count_val} :
                                 {DATA_W{1'b0}};

    // debug pin: first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            dbg_meta_ff <= 1'b0;
            dbg_sync_ff <= 1'b0;
        end else begin
            dbg_meta_ff <= debug_mode;
            dbg_sync_ff <= dbg_meta_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_ff    <= 1'b0;
            win_en_ff <= 1'b0;
        end else if (wr_ctrl) begin
            sel_ff    <= wdata[CTRL_SEL_BIT];
            win_en_ff <= wdata[CTRL_WIN_BIT];
        end
    end

    // reload, window bound and mask registers
    always_ff @(posedge clk) begin
        if (rst) begin
            reload_ff <= RELOAD_RST;
            winb_ff   <= WINB_RST;
            mask_ff   <= MASK_RST;
        end else begin
            if (wr_reload)
                reload_ff <= wdata[7:0];
            if (wr_winb)
                winb_ff   <= wdata[7:0];
            if (wr_mask)
                mask_ff   <= wdata[EV_W-1:0];
        end
    end

    // status and read data
    always_ff @(posedge clk) begin
        if (rst) begin
            status_ff <= {EV_W{1'b0}};
            rdata_ff  <= {DATA_W{1'b0}};
        end else begin
            status_ff <= nxt_status;
            rdata_ff  <= nxt_rdata;
        end
    end

    // timer stages and sequence state
    always_ff @(posedge clk) begin
        if (rst) begin
            lo_ff     <= COUNT_RST[7:0];
            hi_ff     <= COUNT_RST[15:8];
            pw_cnt_ff <= BYTE_ZERO;
            state_ff  <= ST_COUNT;
        end else begin
            lo_ff     <= nxt_lo;
            hi_ff     <= nxt_hi;
            pw_cnt_ff <= nxt_pw_cnt;
            state_ff  <= nxt_state;
        end
    end

    // reset request level
    // both hold until the system reset that they cause
    always_ff @(posedge clk) begin
        if (rst) begin
            nmi_ff     <= 1'b0;
            rst_req_ff <= 1'b0;
        end else begin
            nmi_ff     <= nmi_ff || overflow;
            rst_req_ff <= rst_req_ff || pw_done;
        end
    end

    assign rdata                = rdata_ff;
    assign timeout_nmi          = nmi_ff;
    assign system_reset_request = rst_req_ff;
    assign irq                  = |(status_ff & mask_ff);

    // helper: cycles since the last count tick, for rate checks
    logic [7:0] gap_ff;
    always_ff @(posedge clk) begin
        if (rst || restart || cnt_tick)
            gap_ff <= BYTE_ZERO;
        else if (run)
            gap_ff <= gap_ff + 8'h01;
    end

    property p_carry;
        @(posedge clk) disable iff (rst)
        (counting && cnt_tick && !service_strobe && lo_carry && hi_ff != BYTE_MAX)
        |=> (lo_ff == BYTE_ZERO) && (hi_ff == $past(hi_ff) + 8'h01);
    endproperty
    a_carry: assert property (p_carry) else $error("carry not propagated");

    property p_rate;
        @(posedge clk) disable iff (rst)
        cnt_tick |-> (gap_ff == div_of(sel_ff) - 8'h01);
    endproperty
    a_rate: assert property (p_rate) else $error("count tick spacing wrong");

    property p_service_load;
        @(posedge clk) disable iff (rst)
        svc_accept |=> (hi_ff == $past(reload_ff)) && (lo_ff == BYTE_ZERO)
                       && (state_ff == ST_COUNT);
    endproperty
    a_service_load: assert property (p_service_load) else $error("service load wrong");

    property p_resume;
        @(posedge clk) disable iff (rst)
        (svc_accept && !sel_ff) ##1 (!dbg_sync_ff && !service_strobe && !wr_ctrl) [*2]
        |=> (lo_ff == 8'h01);
    endproperty
    a_resume: assert property (p_resume) else $error("count did not resume");

    property p_nmi;
        @(posedge clk) disable iff (rst)
        overflow |=> timeout_nmi && (state_ff == ST_PREWARN) && (count_val == COUNT_RST)
                     ##1 status_ff[EV_OVF_BIT] || $past(rd_status);
    endproperty
    a_nmi: assert property (p_nmi) else $error("overflow reaction wrong");

    property p_prewarn;
        @(posedge clk) disable iff (rst)
        ((state_ff == ST_PREWARN) && cnt_tick && pw_cnt_ff == PREWARN_COUNTS - 8'h01)
        |=> system_reset_request && (state_ff == ST_RESET);
    endproperty
    a_prewarn: assert property (p_prewarn) else $error("reset request late");

    property p_no_early;
        @(posedge clk) disable iff (rst)
        ((state_ff == ST_PREWARN) && !system_reset_request
         && pw_cnt_ff < PREWARN_COUNTS - 8'h01) |=> !system_reset_request;
    endproperty
    a_no_early: assert property (p_no_early) else $error("reset request early");

    property p_invalid;
        @(posedge clk) disable iff (rst)
        (svc_invalid && !timeout_nmi) |=> (state_ff == ST_PREWARN) && !timeout_nmi;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid refresh handling wrong");

    property p_window;
        @(posedge clk) disable iff (rst)
        (service_strobe && counting && win_en_ff && count_val > {winb_ff, BYTE_ZERO})
        |=> (state_ff == ST_COUNT) && (lo_ff == BYTE_ZERO);
    endproperty
    a_window: assert property (p_window) else $error("legal refresh refused");

    property p_debug;
        @(posedge clk) disable iff (rst)
        (dbg_sync_ff && !service_strobe) |=> $stable(count_val) && $stable(pw_cnt_ff);
    endproperty
    a_debug: assert property (p_debug) else $error("counter moved in debug");

    property p_win_default;
        @(posedge clk)
        $fell(rst) |-> !win_en_ff && !timeout_nmi && !system_reset_request && !irq;
    endproperty
    a_win_default: assert property (p_win_default) else $error("reset state wrong");

endmodule // service_timer

// >>> testbench/sw_service_model.sv
module sw_service_model
(
    // clock
    input  wire logic clk,
    // service request toward the timer
    output var  logic service_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle until software decides to service
    initial begin
        service_strobe = 1'b0;
    end

    task automatic kick();
        @(posedge clk);
        service_strobe <= 1'b1;
        @(posedge clk);
        service_strobe <= 1'b0;
    endtask

endmodule // sw_service_model

// >>> testbench/tb_service_timer.sv
module tb_service_timer
    import wst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // stimulus and observed signals
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_en;
    logic              rd_en;
    logic              debug_mode;
    wire  logic [DATA_W-1:0] rdata;
    wire  logic        service_strobe;
    wire  logic        timeout_nmi;
    wire  logic        system_reset_request;
    wire  logic        irq;
    // bookkeeping
    int                fail_count;
    int                total_checks;
    int                cycle_count;
    logic [7:0]        lfsr_state;
    logic [7:0]        rel;
    logic [31:0]       rd_val;
    logic [31:0]       first_val;
    logic [7:0]        offs [6];

    service_timer service_timer_inst (
        .clk                  (clk),
        .rst                  (rst),
        .addr                 (addr),
        .wdata                (wdata),
        .wr_en                (wr_en),
        .rd_en                (rd_en),
        .rdata                (rdata),
        .service_strobe       (service_strobe),
        .debug_mode           (debug_mode),
        .timeout_nmi          (timeout_nmi),
        .system_reset_request (system_reset_request),
        .irq                  (irq)
    );

    sw_service_model sw_service_model_inst (
        .clk            (clk),
        .service_strobe (service_strobe)
    );

    // free running clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // hang guard: longest test is about six thousand cycles
    always @(posedge clk) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 30000) begin
            fail_count++;
            $display("wrong value at %0t: run too long", $time);
            give_verdict();
        end
    end

    // repeatable pseudo random bytes, never zero
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // cycles from service to overflow
    function automatic int period(input logic sel, input logic [7:0] r);
        return (1 << (1 + 6 * int'(sel))) * (65536 - 256 * int'(r));
    endfunction

    task automatic rnd_byte(output logic [7:0] v);
        lfsr_state = lfsr_next(lfsr_state);
        v = lfsr_state;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        debug_mode <= 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        // let the written register settle before anyone looks
        #1;
    endtask

    // data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    // waits for nmi or reset request, tolerance covers pipeline stages
    task automatic wait_out(input bit pick_nmi, input int exp, input string msg);
        int n;
        n = 0;
        while (n < exp + 8 && (pick_nmi ? timeout_nmi : system_reset_request) !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(n >= exp - 2 && n <= exp + 4), 32'h1, msg);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        debug_mode = 1'b0;
        fail_count = 0;
        total_checks = 0;
        cycle_count = 0;
        lfsr_state = 8'h0E;
        offs = '{CTRL_OFF, RELOAD_OFF, WINB_OFF, STATUS_OFF, MASK_OFF, 8'hFC};
        do_reset();
        foreach (offs[i]) begin
            reg_rd(offs[i], rd_val);
            chk(rd_val, 32'h0, "reset value");
        end
        rnd_byte(rel);
        reg_wr(RELOAD_OFF, {24'hFFFFFF, rel});
        reg_rd(RELOAD_OFF, rd_val);
        chk(rd_val, {24'h0, rel}, "reload readback");
        $display("test reset values done");

        // load, count rate and carry between stages
        do_reset();
        rnd_byte(rel);
        rel = rel & 8'h7F;
        reg_wr(RELOAD_OFF, {24'h0, rel});
        sw_service_model_inst.kick();
        reg_rd(COUNT_OFF, first_val);
        chk(first_val, {16'h0, rel, 8'h00}, "count after service");
        repeat (518) @(posedge clk);
        reg_rd(COUNT_OFF, rd_val);
        chk(rd_val - first_val, 32'h104, "ticks over 520 cycles");
        reg_wr(CTRL_OFF, 32'h1);
        reg_rd(COUNT_OFF, first_val);
        repeat (254) @(posedge clk);
        reg_rd(COUNT_OFF, rd_val);
        chk(rd_val - first_val, 32'h2, "slow ticks over 256 cycles");
        $display("test count rate done");

        // overflow, nmi, prewarning, status and irq
        do_reset();
        rnd_byte(rel);
        rel = rel | 8'hF0;
        reg_wr(MASK_OFF, 32'h1);
        reg_wr(RELOAD_OFF, {24'h0, rel});
        sw_service_model_inst.kick();
        wait_out(1'b1, period(1'b0, rel), "overflow time");
        chk({31'h0, irq}, 32'h1, "irq on overflow");
        wait_out(1'b0, 2 * int'(PREWARN_COUNTS), "prewarning length");
        reg_rd(STATUS_OFF, rd_val);
        chk(rd_val, 32'h5, "status after timeout");
        chk({31'h0, irq}, 32'h0, "irq after status read");
        $display("test timeout done");

        // window boundary: valid just past the bound, invalid inside
        do_reset();
        rnd_byte(rel);
        rel = {1'b0, rel[6:0]} | 8'h01;
        reg_wr(RELOAD_OFF, {24'h0, rel});
        sw_service_model_inst.kick();
        // bound kept at or above reload
        reg_wr(WINB_OFF, {24'h0, rel});
        reg_wr(CTRL_OFF, 32'h2);
        repeat (4) @(posedge clk);
        sw_service_model_inst.kick();
        reg_rd(COUNT_OFF, rd_val);
        chk(rd_val, {16'h0, rel, 8'h00}, "service just past window");
        reg_wr(WINB_OFF, {24'h0, rel + 8'h01});
        sw_service_model_inst.kick();
        wait_out(1'b0, 2 * int'(PREWARN_COUNTS), "invalid refresh prewarning");
        chk({31'h0, timeout_nmi}, 32'h0, "no nmi on invalid refresh");
        chk({31'h0, irq}, 32'h0, "irq masked");
        reg_wr(MASK_OFF, 32'h6);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        reg_rd(STATUS_OFF, rd_val);
        chk(rd_val, 32'h6, "status after invalid refresh");
        chk({31'h0, irq}, 32'h0, "irq cleared by read");
        $display("test window done");

        // debug freeze and resume
        do_reset();
        debug_mode <= 1'b1;
        repeat (6) @(posedge clk);
        reg_rd(COUNT_OFF, first_val);
        repeat (40) @(posedge clk);
        reg_rd(COUNT_OFF, rd_val);
        chk(rd_val, first_val, "count frozen in debug");
        @(posedge clk);
        debug_mode <= 1'b0;
        repeat (10) @(posedge clk);
        reg_rd(COUNT_OFF, rd_val);
        chk(32'(rd_val !== first_val), 32'h1, "count resumes after debug");
        $display("test debug done");
        give_verdict();
    end

endmodule // tb_service_timer
